/* urad_rx_top.sv */
// Serial receiver with nine-bit mode, address detection and an APB register file.
//
// What this block does
// - Nine-bit mode captures nine bits; the ninth lands in the status ninth-bit field.
// - Address detection is enabled by status bit 3 together with nine-bit select.
// - With detection on, the flag rises only when the ninth bit is one.
// - Ninth bit one marks an address byte; zero marks a data byte.
// - With detection on, data bytes are not buffered and raise no flag.
// - An ignored data byte is simply overwritten by the next character.
// - Detection has no effect in eight-bit mode; all characters are received.
// - With detection off every byte is buffered; ninth bit is only delivered.
// - Continuous reception starts when software sets status bit 4.
// - Completion sets the receive flag; interrupt only when its enable is set.
// - Clearing continuous enable clears the overrun error; a buffered framing error stays.
// - Detection works with either continuous or single receive enable.
// - Received data is read at index 1Ah and resets to zero.
// - Unimplemented bits in flag, enable and status registers read zero.
// - Two-entry buffer; the flag clears only once the buffer is read empty.
// - Third character with a full buffer sets overrun, is lost, blocks transfers.
// - Framing error on a low stop bit, buffered with its character.
// - The receive line is oversampled at sixteen times the bit rate.
`timescale 1ns/10ps
`default_nettype none
module urad_rx_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and request
  input  wire logic        rx_line,
  output logic             rx_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                         serial_port_enable_q, rx9_q, single_rx_enable_q, continuous_rx_enable_q, address_detect_enable_q, overrun_error_q;
  logic                         rx_interrupt_enable_q, sync_q, high_speed_baud_select_q;
  logic [7:0]                   baud_q;
  logic [31:0]                  prdata_q;
  logic                         rx_m1_q, rx_m2_q, rx_m3_q, rx_s_q;
  logic [9:0]                   div_q;
  logic [9:0]                   div_lim;
  logic                         tick;
  urad_pkg::urad_rx_state_t     state_q;
  logic [3:0]                   ovs_q;
  logic [3:0]                   bit_q;
  logic [8:0]                   rsr_q;
  logic                         rx_on, done, done_framing_error, ninth, filt, keep;
  logic                         push, ovr_set, pop, empty, full;
  logic [urad_pkg::ENTRY_W-1:0] head;
  logic                         setup, acc, hit, wr;
  logic [9:0]                   widx;
  logic [7:0]                   rd_mux;
  logic                         rx_flag;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign acc   = psel && penable;
  assign widx  = paddr[11:2];
  assign hit   = (widx == {2'b00, urad_pkg::IDX_FLAGS})   ||
                 (widx == {2'b00, urad_pkg::IDX_RXSC})    ||
                 (widx == {2'b00, urad_pkg::IDX_RXDATA})  ||
                 (widx == {2'b00, urad_pkg::IDX_ENABLES}) ||
                 (widx == {2'b00, urad_pkg::IDX_TXSC})    ||
                 (widx == {2'b00, urad_pkg::IDX_BAUD});
  assign wr      = acc && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = prdata_q;

  // status before data
  // Reading the data word advances the buffer, so ninth bit and framing error change with it.
  assign pop = acc && !pwrite && (widx == {2'b00, urad_pkg::IDX_RXDATA}) && !empty;

  always_comb
  begin
    rd_mux = 8'h00;
    case (widx)
      {2'b00, urad_pkg::IDX_FLAGS}:
        rd_mux[urad_pkg::FLAG_RX_BIT] = rx_flag;
      {2'b00, urad_pkg::IDX_RXSC}:
      begin
        rd_mux[urad_pkg::RXSC_SERIAL_PORT_ENABLE_BIT] = serial_port_enable_q;
        rd_mux[urad_pkg::RXSC_RX9_BIT]  = rx9_q;
        rd_mux[urad_pkg::RXSC_SINGLE_RX_ENABLE_BIT] = single_rx_enable_q;
        rd_mux[urad_pkg::RXSC_CONTINUOUS_RX_ENABLE_BIT] = continuous_rx_enable_q;
        rd_mux[urad_pkg::RXSC_ADDRESS_DETECT_ENABLE_BIT] = address_detect_enable_q;
        rd_mux[urad_pkg::RXSC_FRAMING_ERROR_BIT] = head[9];
        rd_mux[urad_pkg::RXSC_OVERRUN_ERROR_BIT] = overrun_error_q;
        rd_mux[urad_pkg::RXSC_R9D_BIT]  = head[8];
      end
      {2'b00, urad_pkg::IDX_RXDATA}:
        rd_mux = head[7:0];
      {2'b00, urad_pkg::IDX_ENABLES}:
        rd_mux[urad_pkg::EN_RX_BIT] = rx_interrupt_enable_q;
      {2'b00, urad_pkg::IDX_TXSC}:
      begin
        rd_mux[urad_pkg::TXSC_SYNC_BIT] = sync_q;
        rd_mux[urad_pkg::TXSC_HIGH_SPEED_BAUD_SELECT_BIT] = high_speed_baud_select_q;
        rd_mux[urad_pkg::TXSC_TRMT_BIT] = 1'b1;
      end
      {2'b00, urad_pkg::IDX_BAUD}:
        rd_mux = baud_q;
      default:
        rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and held through the access cycle.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_q <= {24'h00_0000, rd_mux};
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // continuous receive enable
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      serial_port_enable_q <= urad_pkg::RXSC_RST[urad_pkg::RXSC_SERIAL_PORT_ENABLE_BIT];
      rx9_q  <= urad_pkg::RXSC_RST[urad_pkg::RXSC_RX9_BIT];
      continuous_rx_enable_q <= urad_pkg::RXSC_RST[urad_pkg::RXSC_CONTINUOUS_RX_ENABLE_BIT];
      address_detect_enable_q <= urad_pkg::RXSC_RST[urad_pkg::RXSC_ADDRESS_DETECT_ENABLE_BIT];
    end
    else if (wr && widx == {2'b00, urad_pkg::IDX_RXSC})
    begin
      serial_port_enable_q <= pwdata[urad_pkg::RXSC_SERIAL_PORT_ENABLE_BIT];
      rx9_q  <= pwdata[urad_pkg::RXSC_RX9_BIT];
      continuous_rx_enable_q <= pwdata[urad_pkg::RXSC_CONTINUOUS_RX_ENABLE_BIT];
      address_detect_enable_q <= pwdata[urad_pkg::RXSC_ADDRESS_DETECT_ENABLE_BIT];
    end
  end

  // single receive enable
  // The single enable drops by itself once one kept character has completed while continuous enable is clear.
  // A data byte dropped by address detection leaves it armed for the next address.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      single_rx_enable_q <= urad_pkg::RXSC_RST[urad_pkg::RXSC_SINGLE_RX_ENABLE_BIT];
    else if (wr && widx == {2'b00, urad_pkg::IDX_RXSC})
      single_rx_enable_q <= pwdata[urad_pkg::RXSC_SINGLE_RX_ENABLE_BIT];
    else if (done && keep && !continuous_rx_enable_q)
      single_rx_enable_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync_q <= urad_pkg::TXSC_RST[urad_pkg::TXSC_SYNC_BIT];
      high_speed_baud_select_q <= urad_pkg::TXSC_RST[urad_pkg::TXSC_HIGH_SPEED_BAUD_SELECT_BIT];
    end
    else if (wr && widx == {2'b00, urad_pkg::IDX_TXSC})
    begin
      sync_q <= pwdata[urad_pkg::TXSC_SYNC_BIT];
      high_speed_baud_select_q <= pwdata[urad_pkg::TXSC_HIGH_SPEED_BAUD_SELECT_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rx_interrupt_enable_q <= 1'b0;
    else if (wr && widx == {2'b00, urad_pkg::IDX_ENABLES})
      rx_interrupt_enable_q <= pwdata[urad_pkg::EN_RX_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      baud_q <= urad_pkg::BAUD_RST;
    else if (wr && widx == {2'b00, urad_pkg::IDX_BAUD})
      baud_q <= pwdata[7:0];
  end

  // clear overrun error
  // An overrun in the same cycle as the clear still wins.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      overrun_error_q <= 1'b0;
    else if (ovr_set)
      overrun_error_q <= 1'b1;
    else if (!continuous_rx_enable_q)
      overrun_error_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Line synchroniser and oversampling clock
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_m1_q <= 1'b1;
      rx_m2_q <= 1'b1;
      rx_m3_q <= 1'b1;
      rx_s_q  <= 1'b1;
    end
    else
    begin
      rx_m1_q <= rx_line;
      rx_m2_q <= rx_m1_q;
      rx_m3_q <= rx_m2_q;
      if (rx_m2_q == rx_m3_q)
        rx_s_q <= rx_m2_q;
    end
  end

  // port enable gating
  // Only the asynchronous frame is recovered; synchronous select keeps the receiver idle.
  assign rx_on = serial_port_enable_q && !sync_q && (continuous_rx_enable_q || single_rx_enable_q);

  // sixteen-fold oversampling
  // Low speed divides by four more, so one tick lasts 4*(divisor+1) clocks.
  assign div_lim = high_speed_baud_select_q ? {2'b00, baud_q} : {baud_q, 2'b11};
  assign tick    = rx_on && (div_q == div_lim);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      div_q <= 10'h000;
    else if (!rx_on || tick)
      div_q <= 10'h000;
    else
      div_q <= div_q + 10'h001;
  end

  // ----------------------------------------------------------------
  // Character recovery
  // ----------------------------------------------------------------
  // start, data, stop framing
  always_ff @(posedge clock)
  begin
    if (!rst_n || !rx_on)
    begin
      state_q <= urad_pkg::RX_IDLE;
      ovs_q   <= 4'h0;
      bit_q   <= 4'h0;
    end
    else if (tick)
    begin
      case (state_q)
        urad_pkg::RX_IDLE:
          if (!rx_s_q)
          begin
            state_q <= urad_pkg::RX_START;
            ovs_q   <= 4'h0;
          end
        urad_pkg::RX_START:
          if (ovs_q == urad_pkg::OVS_MID)
          begin
            state_q <= rx_s_q ? urad_pkg::RX_IDLE : urad_pkg::RX_DATA;
            ovs_q   <= 4'h0;
            bit_q   <= 4'h0;
          end
          else
            ovs_q <= ovs_q + 4'h1;
        urad_pkg::RX_DATA:
          if (ovs_q == urad_pkg::OVS_LAST)
          begin
            ovs_q <= 4'h0;
            if (bit_q == (rx9_q ? urad_pkg::LAST_BIT9 : urad_pkg::LAST_BIT8))
              state_q <= urad_pkg::RX_STOP;
            else
              bit_q <= bit_q + 4'h1;
          end
          else
            ovs_q <= ovs_q + 4'h1;
        urad_pkg::RX_STOP:
          if (ovs_q == urad_pkg::OVS_LAST)
            state_q <= urad_pkg::RX_IDLE;
          else
            ovs_q <= ovs_q + 4'h1;
        default:
          state_q <= urad_pkg::RX_IDLE;
      endcase
    end
  end

  // shift register overwritten
  // Each bit lands straight at its own position, so a dropped byte needs no clearing.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rsr_q <= 9'h000;
    else if (tick && state_q == urad_pkg::RX_DATA && ovs_q == urad_pkg::OVS_LAST)
      rsr_q[bit_q] <= rx_s_q;
  end

  assign done      = tick && state_q == urad_pkg::RX_STOP && ovs_q == urad_pkg::OVS_LAST;
  assign done_framing_error = !rx_s_q;

  assign ninth = rx9_q && rsr_q[8];

  assign filt = address_detect_enable_q && rx9_q;

  assign keep = !filt || ninth;

  assign push    = done && keep && !overrun_error_q && !full;
  assign ovr_set = done && keep && !overrun_error_q && full;

  urad_rx_fifo u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .push      (push),
    .push_data ({done_framing_error, ninth, rsr_q[7:0]}),
    .pop       (pop),
    .head      (head),
    .empty     (empty),
    .full      (full)
  );

  assign rx_flag = !empty;
  assign rx_irq  = rx_flag && rx_interrupt_enable_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_ninth_store: assert property (push |=> head[8] == $past(ninth) || !$past(empty))
    else $error("ninth bit not stored with character");
  chk_addr_taken: assert property (done && filt && rsr_q[8] && !overrun_error_q && !full |=> rx_flag)
    else $error("address byte did not raise the flag");
  chk_data_dropped: assert property (done && filt && !rsr_q[8] |-> !push && !ovr_set)
    else $error("data byte buffered while detection active");
  chk_eight_bit: assert property (done && !rx9_q && !overrun_error_q && !full |-> push)
    else $error("eight-bit character not buffered");
  chk_no_detect: assert property (done && !address_detect_enable_q && !overrun_error_q && !full |-> push)
    else $error("character lost with detection off");
  chk_irq_gate: assert property (push && !rx_interrupt_enable_q ##1 !rx_interrupt_enable_q |-> rx_flag && !rx_irq)
    else $error("request raised without enable");
  chk_err_clear: assert property (!continuous_rx_enable_q && !ovr_set |=> !overrun_error_q)
    else $error("overrun survived continuous enable clear");
  chk_flag_clear: assert property (pop && !push && !full |=> !rx_flag)
    else $error("flag remained after buffer emptied");
  chk_overrun_set: assert property (ovr_set && !pop |=> overrun_error_q && full)
    else $error("overrun not flagged or buffer changed");
  chk_framing_error_stop: assert property (push && empty |=> head[9] == $past(done_framing_error))
    else $error("framing error not buffered");
  chk_tick_space: assert property (tick && !high_speed_baud_select_q && baud_q == 8'h00 ##1 rx_on
    |-> !tick ##1 !tick ##1 !tick)
    else $error("oversampling tick came too early");

  cov_addr_kept: cover property (done && filt && rsr_q[8] && push);
  cov_data_drop: cover property (done && filt && !rsr_q[8]);
  cov_overrun: cover property (ovr_set);
  cov_two_deep: cover property (full ##1 pop);

endmodule : urad_rx_top
`default_nettype wire

/* urad_pkg.sv */
// Shared constants and types of the receive path with address detection.
package urad_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_RXSC    = 8'h18;
  localparam logic [7:0] IDX_RXDATA  = 8'h1A;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TXSC    = 8'h98;
  localparam logic [7:0] IDX_BAUD    = 8'h99;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_RX_BIT   = 5;
  localparam int unsigned EN_RX_BIT     = 5;
  localparam int unsigned RXSC_SERIAL_PORT_ENABLE_BIT = 7;
  localparam int unsigned RXSC_RX9_BIT  = 6;
  localparam int unsigned RXSC_SINGLE_RX_ENABLE_BIT = 5;
  localparam int unsigned RXSC_CONTINUOUS_RX_ENABLE_BIT = 4;
  localparam int unsigned RXSC_ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int unsigned RXSC_FRAMING_ERROR_BIT = 2;
  localparam int unsigned RXSC_OVERRUN_ERROR_BIT = 1;
  localparam int unsigned RXSC_R9D_BIT  = 0;
  localparam int unsigned TXSC_SYNC_BIT = 4;
  localparam int unsigned TXSC_HIGH_SPEED_BAUD_SELECT_BIT = 2;
  localparam int unsigned TXSC_TRMT_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RXSC_RST  = 8'h00;
  localparam logic [7:0] TXSC_RST  = 8'h02;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [7:0] RXDAT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] OVS_MID   = 4'h7;
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam int unsigned ENTRY_W  = 10;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urad_rx_state_t;

endpackage : urad_pkg

/* urad_rx_fifo.sv */
// Two-entry receive buffer holding data, ninth bit and framing error per character.
`timescale 1ns/10ps
`default_nettype none
module urad_rx_fifo (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  // Write side
  input  wire logic                            push,
  input  wire logic [urad_pkg::ENTRY_W-1:0]    push_data,
  // Read side
  input  wire logic                            pop,
  output logic      [urad_pkg::ENTRY_W-1:0]    head,
  output logic                                 empty,
  output logic                                 full
);

  logic [urad_pkg::ENTRY_W-1:0] mem_q [2];
  logic                         wp_q;
  logic                         rp_q;
  logic [1:0]                   cnt_q;

  assign head  = mem_q[rp_q];
  assign empty = (cnt_q == 2'h0);
  assign full  = (cnt_q == 2'h2);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
    end
    else if (push && !full)
    begin
      mem_q[wp_q] <= push_data;
      wp_q        <= ~wp_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rp_q <= 1'b0;
    else if (pop && !empty)
      rp_q <= ~rp_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_q <= 2'h0;
    else if ((push && !full) && !(pop && !empty))
      cnt_q <= cnt_q + 2'h1;
    else if (!(push && !full) && (pop && !empty))
      cnt_q <= cnt_q - 2'h1;
  end

endmodule : urad_rx_fifo
`default_nettype wire

/* urad_tx_model.sv */
// Behavioural serial transmitter that drives the receive line of the block.
`timescale 1ns/10ps
`default_nettype none
module urad_tx_model #(
  parameter int BIT_CLOCKS = 16
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Character request
  input  wire logic       go,
  input  wire logic       nine,
  input  wire logic       stop_ok,
  input  wire logic [8:0] data,
  input  wire logic       slow,
  // Serial side
  output logic            line,
  output logic            busy
);
  logic [10:0] frame_q;
  int          tick_q;
  int          bit_q;

  // idle high line
  // Between frames the line sits high, as a pulled-up receive pin would.
  assign line = busy ? frame_q[0] : 1'b1;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busy    <= 1'b0;
      frame_q <= 11'h7FF;
      tick_q  <= 0;
      bit_q   <= 0;
    end
    else if (!busy && go)
    begin
      frame_q <= nine ? {stop_ok, data, 1'b0} : {1'b1, stop_ok, data[7:0], 1'b0};
      busy    <= 1'b1;
      tick_q  <= 0;
      bit_q   <= 0;
    end
    else if (busy)
    begin
      // Slow bits last four times longer, matching the receiver's low-speed divide.
      if (tick_q == (slow ? 4 * BIT_CLOCKS : BIT_CLOCKS) - 1)
      begin
        tick_q  <= 0;
        frame_q <= {1'b1, frame_q[10:1]};
        bit_q   <= bit_q + 1;
        if (bit_q == 10)
        begin
          busy <= 1'b0;
        end
      end
      else
      begin
        tick_q <= tick_q + 1;
      end
    end
  end
endmodule : urad_tx_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the receive path with address detection.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module testbench;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        rx_irq;
  logic        tx_go;
  logic        tx_nine;
  logic        tx_stop_ok;
  logic [8:0]  tx_data;
  logic        tx_busy;
  logic        tx_slow;
  int          miscompares;
  int          samples_checked;
  int          cycle_count;
  localparam int CYCLE_LIMIT = 30000;

  urad_rx_top i_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .rx_irq(rx_irq));
  // With baud 0 and high speed select, one bit lasts sixteen core clocks.
  urad_tx_model #(.BIT_CLOCKS(16)) i_tx (
    .clock(clock), .rst_n(rst_n), .go(tx_go), .nine(tx_nine), .stop_ok(tx_stop_ok),
    .data(tx_data), .slow(tx_slow), .line(rx_line), .busy(tx_busy));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycle_count++;
    if (cycle_count == CYCLE_LIMIT)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t timeout", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus and line tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask : wr

  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 8'h00, rd, err);
    `CHK(rd, {24'h000000, exp}, $sformatf("index %0h read %0h exp %0h", idx, rd, exp))
    `CHK(err, 1'b0, "unexpected slave error")
  endtask : expect_reg

  task automatic expect_flag(input logic flag, input logic irq);
    expect_reg(urad_pkg::IDX_FLAGS, flag ? 8'h20 : 8'h00);
    `CHK(rx_irq, irq, "interrupt request level")
  endtask : expect_flag

  task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok);
    tx_data    <= d;
    tx_nine    <= nine;
    tx_stop_ok <= stop_ok;
    tx_go      <= 1'b1;
    @(posedge clock);
    tx_go <= 1'b0;
    do
      @(posedge clock);
    while (tx_busy === 1'b1);
    repeat (8) @(posedge clock);
  endtask : send

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    logic [31:0] rd;
    logic        err;
    expect_reg(urad_pkg::IDX_FLAGS, 8'h00);
    expect_reg(urad_pkg::IDX_RXSC, 8'h00);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h00);
    expect_reg(urad_pkg::IDX_ENABLES, 8'h00);
    expect_reg(urad_pkg::IDX_TXSC, 8'h02);
    expect_reg(urad_pkg::IDX_BAUD, 8'h00);
    apb(1'b0, 8'h19, 8'h00, rd, err);
    `CHK(err, 1'b1, "unmapped index not refused")
    `CHK(rd, 32'h00000000, "unmapped index read data")
    $display("test_reset done");
  endtask : test_reset

  task automatic test_eight_bit;
    wr(urad_pkg::IDX_BAUD, 8'h00);
    wr(urad_pkg::IDX_TXSC, 8'h04);
    wr(urad_pkg::IDX_ENABLES, 8'h20);
    wr(urad_pkg::IDX_RXSC, 8'h88);
    send(9'h0A5, 1'b0, 1'b1);
    expect_flag(1'b0, 1'b0);
    wr(urad_pkg::IDX_RXSC, 8'h98);
    send(9'h0A5, 1'b0, 1'b1);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'h98);
    expect_reg(urad_pkg::IDX_RXDATA, 8'hA5);
    expect_flag(1'b0, 1'b0);
    wr(urad_pkg::IDX_ENABLES, 8'h00);
    send(9'h03C, 1'b0, 1'b1);
    expect_flag(1'b1, 1'b0);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h3C);
    wr(urad_pkg::IDX_ENABLES, 8'h20);
    $display("test_eight_bit done");
  endtask : test_eight_bit

  task automatic test_nine_bit;
    wr(urad_pkg::IDX_RXSC, 8'hD0);
    send(9'h15A, 1'b1, 1'b1);
    send(9'h0C3, 1'b1, 1'b1);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'hD1);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h5A);
    expect_reg(urad_pkg::IDX_RXSC, 8'hD0);
    expect_reg(urad_pkg::IDX_RXDATA, 8'hC3);
    $display("test_nine_bit done");
  endtask : test_nine_bit

  task automatic test_address_detect;
    wr(urad_pkg::IDX_RXSC, 8'hD8);
    send(9'h011, 1'b1, 1'b1);
    expect_flag(1'b0, 1'b0);
    send(9'h022, 1'b1, 1'b1);
    send(9'h1AB, 1'b1, 1'b1);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'hD9);
    expect_reg(urad_pkg::IDX_RXDATA, 8'hAB);
    expect_flag(1'b0, 1'b0);
    wr(urad_pkg::IDX_RXSC, 8'hD0);
    send(9'h044, 1'b1, 1'b1);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h44);
    wr(urad_pkg::IDX_RXSC, 8'hE8);
    send(9'h011, 1'b1, 1'b1);
    send(9'h155, 1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'hC9);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h55);
    $display("test_address_detect done");
  endtask : test_address_detect

  task automatic test_overrun;
    wr(urad_pkg::IDX_RXSC, 8'h90);
    send(9'h001, 1'b0, 1'b1);
    send(9'h002, 1'b0, 1'b1);
    send(9'h003, 1'b0, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'h92);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h01);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h02);
    expect_flag(1'b0, 1'b0);
    send(9'h004, 1'b0, 1'b1);
    expect_flag(1'b0, 1'b0);
    wr(urad_pkg::IDX_RXSC, 8'h80);
    expect_reg(urad_pkg::IDX_RXSC, 8'h80);
    $display("test_overrun done");
  endtask : test_overrun

  task automatic test_framing;
    wr(urad_pkg::IDX_RXSC, 8'h90);
    send(9'h066, 1'b0, 1'b0);
    send(9'h077, 1'b0, 1'b1);
    expect_reg(urad_pkg::IDX_RXSC, 8'h94);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h66);
    expect_reg(urad_pkg::IDX_RXSC, 8'h90);
    expect_reg(urad_pkg::IDX_RXDATA, 8'h77);
    $display("test_framing done");
  endtask : test_framing

  task automatic test_low_speed;
    wr(urad_pkg::IDX_TXSC, 8'h14);
    wr(urad_pkg::IDX_RXSC, 8'h90);
    send(9'h05A, 1'b0, 1'b1);
    expect_flag(1'b0, 1'b0);
    wr(urad_pkg::IDX_TXSC, 8'h00);
    tx_slow <= 1'b1;
    send(9'h0E7, 1'b0, 1'b1);
    expect_flag(1'b1, 1'b1);
    expect_reg(urad_pkg::IDX_RXDATA, 8'hE7);
    tx_slow <= 1'b0;
    $display("test_low_speed done");
  endtask : test_low_speed

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    tx_go = 1'b0;
    tx_nine = 1'b0;
    tx_stop_ok = 1'b1;
    tx_data = 9'h000;
    tx_slow = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cycle_count = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_eight_bit();
    test_nine_bit();
    test_address_detect();
    test_overrun();
    test_framing();
    test_low_speed();
    summarize();
  end
endmodule : testbench
`default_nettype wire
